// >>> core/pet_timer.sv
`timescale 1ns/10ps
module pet_timer
  import pet_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Instruction executor strobes
  input pet_cpu_op_t cpuOp,
  // External event pin, asynchronous
  input wire logic eventPin,
  // Answers to the executor
  output logic [PET_COUNT_W-1:0] readCount,
  output logic readValid,
  output logic skipTaken,
  output logic skipValid,
  // Status
  output logic overflowTestFlag,
  output logic counterOverflow,
  output logic standbyRelease,
  output logic [1:0] sourceSel,
  output logic cpuClockPhase
);

  pet_mode_t modeSel_r;
  logic [PET_COUNT_W-1:0] count_r;
  logic [PET_COUNT_W-1:0] readCount_r;
  logic readValid_r;
  logic skipTaken_r;
  logic skipValid_r;
  logic flag_r;
  logic ovfPulse_r;
  logic release_r;
  logic cpuPhase_r;
  logic evSync1_r;
  logic evSync2_r;
  logic evPrev_r;
  logic pending_r;
  logic preTick;
  logic eventRise;
  logic countPulse;
  logic pulseEff;
  logic overflowEv;
  logic flag_nxt;

  // Mode field write; acc bit 0 is the other party's duty and is ignored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      modeSel_r <= PET_MODE_RST;
    end else if (cpuOp.portOutOp) begin
      modeSel_r <= pet_mode_t'({cpuOp.acc[PET_ACC_SEL_HI],
                                cpuOp.acc[PET_ACC_SEL_LO]});
    end
  end

  pet_prescaler u_prescaler (
    .clk(clk),
    .nrst(nrst),
    .clear(cpuOp.clearStartOp),
    .modeSel(modeSel_r),
    .preTick(preTick)
  );

  // Event pin synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge clk) begin
    if (!nrst) begin
      evSync1_r <= 1'b0;
      evSync2_r <= 1'b0;
      evPrev_r <= 1'b0;
    end else begin
      evSync1_r <= eventPin;
      evSync2_r <= evSync1_r;
      evPrev_r <= evSync2_r;
    end
  end

  assign eventRise = evSync2_r && !evPrev_r;

  // Source multiplexer
  always_comb begin
    case (modeSel_r)
      PET_EVENT: countPulse = eventRise;
      PET_DIV4, PET_DIV32, PET_DIV256: countPulse = preTick;
      default: countPulse = 1'b0;
    endcase
  end

  // A pulse landing in a read is parked and applied after it, so the
  // read never sees a moving value and no pulse is lost
  assign pulseEff = (countPulse || pending_r) && !cpuOp.countReadOp;
  assign overflowEv = pulseEff && (count_r == PET_COUNT_MAX)
                      && !cpuOp.clearStartOp;

  always_ff @(posedge clk) begin
    if (!nrst || cpuOp.clearStartOp) begin
      pending_r <= 1'b0;
    end else begin
      pending_r <= cpuOp.countReadOp && (countPulse || pending_r);
    end
  end

  // Count register; wrap to zero falls out of the 8-bit add
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_r <= PET_COUNT_RST;
    end else if (cpuOp.clearStartOp) begin
      count_r <= PET_COUNT_RST;
    end else if (pulseEff) begin
      count_r <= count_r + PET_COUNT_ONE;
    end
  end

  // Overflow test flag: a new overflow wins over a same-cycle skip test
  always_comb begin
    flag_nxt = flag_r;
    if (overflowEv) begin
      flag_nxt = 1'b1;
    end else if (cpuOp.flagSkipTestOp || cpuOp.clearStartOp) begin
      flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_r <= 1'b0;
      ovfPulse_r <= 1'b0;
      release_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      ovfPulse_r <= overflowEv;
      release_r <= flag_nxt;
    end
  end

  // Skip answer reports the flag as it stood when tested
  always_ff @(posedge clk) begin
    if (!nrst) begin
      skipTaken_r <= 1'b0;
      skipValid_r <= 1'b0;
    end else begin
      skipValid_r <= cpuOp.flagSkipTestOp;
      skipTaken_r <= cpuOp.flagSkipTestOp && flag_r;
    end
  end

  // Count read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      readCount_r <= PET_COUNT_RST;
      readValid_r <= 1'b0;
    end else begin
      readValid_r <= cpuOp.countReadOp;
      if (cpuOp.countReadOp) begin
        readCount_r <= count_r;
      end
    end
  end

  // CPU clock phase at half the system rate
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cpuPhase_r <= 1'b0;
    end else begin
      cpuPhase_r <= !cpuPhase_r;
    end
  end

  assign readCount = readCount_r;
  assign readValid = readValid_r;
  assign skipTaken = skipTaken_r;
  assign skipValid = skipValid_r;
  assign overflowTestFlag = flag_r;
  assign counterOverflow = ovfPulse_r;
  assign standbyRelease = release_r;
  assign sourceSel = modeSel_r;
  assign cpuClockPhase = cpuPhase_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_div4_run;
    (preTick && modeSel_r == PET_DIV4)
    ##1 (!cpuOp.clearStartOp && modeSel_r == PET_DIV4) [*3]
    ##1 (modeSel_r == PET_DIV4);
  endsequence

  sequence s_wrap_step;
    pulseEff && count_r == PET_COUNT_MAX && !cpuOp.clearStartOp;
  endsequence

  a_mode_load: assert property (
    cpuOp.portOutOp |=> modeSel_r == pet_mode_t'(
      {$past(cpuOp.acc[PET_ACC_SEL_HI]), $past(cpuOp.acc[PET_ACC_SEL_LO])}))
    else $error("mode field not loaded from acc bits 2 and 1");

  a_div4_rate: assert property (
    s_div4_run |-> preTick)
    else $error("divide by 4 tick missing");

  a_div4_quiet: assert property (
    (preTick && modeSel_r == PET_DIV4) ##1 !cpuOp.clearStartOp |-> !preTick)
    else $error("divide by 4 tick too early");

  a_count_step: assert property (
    (pulseEff && !cpuOp.clearStartOp) |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not step by one");

  a_clear_wins: assert property (
    cpuOp.clearStartOp |=> count_r == PET_COUNT_RST && !counterOverflow
      && !overflowTestFlag)
    else $error("clear did not win over count pulse");

  a_wrap_flag: assert property (
    s_wrap_step |=> count_r == PET_COUNT_RST && counterOverflow
      && overflowTestFlag && standbyRelease)
    else $error("wrap did not raise overflow and flag");

  a_skip_clears: assert property (
    (cpuOp.flagSkipTestOp && !overflowEv) |=> !overflowTestFlag)
    else $error("skip test did not clear flag");

  a_read_value: assert property (
    cpuOp.countReadOp |=> readValid && readCount == $past(count_r))
    else $error("count read returned wrong value");

  a_read_hold: assert property (
    (cpuOp.countReadOp && !cpuOp.clearStartOp) |=> count_r == $past(count_r))
    else $error("count changed during read");

  a_event_count: assert property (
    (eventRise && modeSel_r == PET_EVENT && !cpuOp.countReadOp
      && !cpuOp.clearStartOp && count_r != PET_COUNT_MAX)
      |=> count_r == $past(count_r) + 8'h01)
    else $error("event edge not counted");

  a_release_flag: assert property (
    $rose(overflowTestFlag) |-> standbyRelease)
    else $error("standby release did not follow flag");

  a_cpu_clock: assert property (
    cpuClockPhase |=> !cpuClockPhase ##1 cpuClockPhase)
    else $error("cpu clock not system clock over two");

endmodule

// >>> common/pet_pkg.sv
package pet_pkg;

  // Count pulse source codes, as loaded into the source select field
  typedef enum logic [1:0] {
    PET_DIV256 = 2'b00,
    PET_EVENT  = 2'b01,
    PET_DIV32  = 2'b10,
    PET_DIV4   = 2'b11
  } pet_mode_t;

  // One cycle strobes from the instruction executor
  typedef struct packed {
    logic       portOutOp;
    logic       clearStartOp;
    logic       countReadOp;
    logic       flagSkipTestOp;
    logic [3:0] acc;
  } pet_cpu_op_t;

  localparam int PET_COUNT_W = 8;
  localparam int PET_PRE_W = 8;
  localparam int PET_ACC_SEL_HI = 2;
  localparam int PET_ACC_SEL_LO = 1;
  localparam logic [PET_COUNT_W-1:0] PET_COUNT_RST = 8'h00;
  localparam logic [PET_COUNT_W-1:0] PET_COUNT_MAX = 8'hff;
  localparam logic [PET_COUNT_W-1:0] PET_COUNT_ONE = 8'h01;
  localparam logic [PET_PRE_W-1:0] PET_PRE_RST = 8'h00;
  localparam logic [PET_PRE_W-1:0] PET_PRE_ONE = 8'h01;
  localparam logic [PET_PRE_W-1:0] PET_MASK_DIV4 = 8'h03;
  localparam logic [PET_PRE_W-1:0] PET_MASK_DIV32 = 8'h1f;
  localparam logic [PET_PRE_W-1:0] PET_MASK_DIV256 = 8'hff;
  localparam pet_mode_t PET_MODE_RST = PET_DIV256;

endpackage

// >>> core/pet_prescaler.sv
`timescale 1ns/10ps
module pet_prescaler
  import pet_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic clear,
  input pet_mode_t modeSel,
  // Tick towards the counter
  output logic preTick
);

  logic [PET_PRE_W-1:0] preCnt_r;
  logic [PET_PRE_W-1:0] mask;

  // One free-running divider serves all three ratios, so a mode change
  // takes effect at the next boundary of the new ratio
  always_comb begin
    case (modeSel)
      PET_DIV4: mask = PET_MASK_DIV4;
      PET_DIV32: mask = PET_MASK_DIV32;
      PET_DIV256: mask = PET_MASK_DIV256;
      default: mask = PET_MASK_DIV256;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst || clear) begin
      preCnt_r <= PET_PRE_RST;
    end else begin
      preCnt_r <= preCnt_r + PET_PRE_ONE;
    end
  end

  assign preTick = (modeSel != PET_EVENT) && ((preCnt_r & mask) == mask);

endmodule

// >>> testbench/pet_event_source.sv
`timescale 1ns/10ps
module pet_event_source (
  // Clock
  input wire logic clk,
  // Burst request from the bench
  input wire logic go,
  input wire logic [7:0] edges,
  input wire logic [3:0] holdCycles,
  // Event pin and status
  output logic eventPin,
  output logic busy
);
  // Pin levels change off the sampling edge, each held holdCycles clocks
  initial begin
    eventPin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        busy = 1'b1;
        for (int i = 0; i < edges; i++) begin
          @(negedge clk);
          eventPin = 1'b1;
          repeat (holdCycles) @(negedge clk);
          eventPin = 1'b0;
          repeat (holdCycles - 1) @(negedge clk);
        end
        busy = 1'b0;
      end
    end
  end
endmodule

// >>> testbench/test_prescaled_event_timer.sv
`timescale 1ns/10ps
module test_prescaled_event_timer
  import pet_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  pet_cpu_op_t op = '0;
  logic eventPin, readValid, skipTaken, skipValid, ovfFlag;
  logic counterOverflow, standbyRelease, cpuClockPhase, evGo, evBusy;
  logic [PET_COUNT_W-1:0] readCount;
  logic [7:0] evEdges;
  logic [3:0] evHold;
  logic [1:0] sourceSel;
  int err_total = 0;
  int checks_done = 0;
  int ovfPulses = 0;
  int n;
  logic p;
  pet_mode_t mt[3] = '{PET_DIV4, PET_DIV32, PET_DIV256};
  int wt[3] = '{20, 110, 638};
  logic [7:0] et[3] = '{8'h05, 8'h03, 8'h02};

  pet_timer i_pet_timer (.clk(clk), .nrst(nrst), .cpuOp(op),
    .eventPin(eventPin), .readCount(readCount), .readValid(readValid),
    .skipTaken(skipTaken), .skipValid(skipValid),
    .overflowTestFlag(ovfFlag), .counterOverflow(counterOverflow),
    .standbyRelease(standbyRelease), .sourceSel(sourceSel),
    .cpuClockPhase(cpuClockPhase));
  pet_event_source i_pet_event_source (.clk(clk), .go(evGo),
    .edges(evEdges), .holdCycles(evHold), .eventPin(eventPin),
    .busy(evBusy));

  always #20 clk = ~clk;
  always @(posedge clk) if (counterOverflow === 1'b1) ovfPulses++;

  task check(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task test_done;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task idle(input int c);
    repeat (c) @(negedge clk);
  endtask
  // One-cycle strobe: 0 mode write, 1 clear, 2 read, 3 skip test
  task strobe(input int w, input logic [3:0] acc);
    @(negedge clk);
    op.acc = acc;
    op.portOutOp = (w == 0);
    op.clearStartOp = (w == 1);
    op.countReadOp = (w == 2);
    op.flagSkipTestOp = (w == 3);
    @(negedge clk);
    op = '0;
  endtask
  task setMode(input pet_mode_t m);
    strobe(0, {1'b0, m, 1'b0});
    check({6'h00, sourceSel}, {6'h00, m}, "mode");
  endtask
  task readExp(input logic [7:0] e);
    strobe(2, 4'h0);
    check({7'h00, readValid}, 8'h01, "read valid");
    check(readCount, e, "count");
  endtask
  task skipExp(input logic t);
    strobe(3, 4'h0);
    check({6'h00, skipValid, skipTaken}, {6'h00, 1'b1, t}, "skip");
    check({7'h00, ovfFlag}, 8'h00, "flag after skip");
  endtask
  task waitFlag;
    for (n = 0; n < 1100 && ovfFlag !== 1'b1; n++) @(negedge clk);
    check({7'h00, n >= 1022 && n <= 1027}, 8'h01, "wrap time");
    if (n >= 1100) test_done();
  endtask
  task burst(input logic [7:0] e, input logic [3:0] h);
    evEdges = e;
    evHold = h;
    evGo = 1'b1;
    idle(1);
    evGo = 1'b0;
    for (n = 0; n < 200 && evBusy === 1'b1; n++) @(negedge clk);
    if (n >= 200) begin
      check(8'h00, 8'h01, "event burst hung");
      test_done();
    end
    idle(5);
  endtask

  initial begin
    repeat (10000) @(posedge clk);
    check(8'h00, 8'h01, "run too long");
    test_done();
  end

  initial begin
    evGo = 1'b0;
    evEdges = 8'h00;
    evHold = 4'h2;
    idle(3);
    nrst = 1'b1;
    check({5'h00, sourceSel, ovfFlag}, 8'h00, "reset state");
    readExp(8'h00);
    p = cpuClockPhase;
    idle(1);
    check({7'h00, cpuClockPhase}, {7'h00, ~p}, "cpu phase");
    for (int i = 0; i < 3; i++) begin
      setMode(mt[i]);
      strobe(1, 4'h0);
      idle(wt[i]);
      readExp(et[i]);
    end
    // Read lands on a divide-by-4 tick; the parked pulse must follow it
    setMode(PET_DIV4);
    strobe(1, 4'h0);
    idle(22);
    readExp(8'h05);
    readExp(8'h06);
    $display("Prescaler test done");
    setMode(PET_DIV4);
    strobe(1, 4'h0);
    waitFlag();
    check({6'h00, standbyRelease, ovfFlag}, 8'h03, "release");
    // The pulse counter samples on the edge after the overflow pulse
    idle(1);
    check(ovfPulses[7:0], 8'h01, "overflow pulses");
    strobe(1, 4'h0);
    check({7'h00, ovfFlag}, 8'h00, "flag after clear");
    waitFlag();
    skipExp(1'b1);
    skipExp(1'b0);
    $display("Overflow test done");
    setMode(PET_EVENT);
    strobe(1, 4'h0);
    burst(8'h07, 4'h2);
    readExp(8'h07);
    burst(8'h03, 4'h5);
    readExp(8'h0a);
    $display("Event test done");
    test_done();
  end
endmodule
